// File: include/rrx_pkg.sv
// package: opcodes, field layout and constants of the return/rotate execution unit
// Summary of operation
// - interrupt exit pops stack into PC
// - interrupt exit sets enable bit seven
// - interrupt exit: one word, two cycles, flags kept
// - subroutine exit pops stack, two cycles, flags kept
// - literal exit loads W with literal
// - literal exit loads PC from stack top
// - left rotate shifts toward MSB through carry
// - right rotate shifts toward LSB through carry
// - destination bit: 0 to W, 1 to file
package rrx_pkg;
  localparam int unsigned PC_W   = 15;
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned WORD_W = 14;
  localparam logic [2:0]  IRQ_EN_BIT = 3'h7;
  // opcode words (14-bit); rotate fields: [13:8] op, [7] dest, [6:0] address
  localparam logic [13:0] OP_RETURN = 14'h0008;
  localparam logic [13:0] OP_RETFI  = 14'h0009;
  localparam logic [5:0]  OP_RETLIT = 6'h34;
  localparam logic [5:0]  OP_ROTR   = 6'h0c;
  localparam logic [5:0]  OP_ROTL   = 6'h0d;
  localparam int unsigned OPC_LSB  = 8;
  localparam int unsigned DEST_BIT = 7;
  localparam logic [7:0]  W_RST    = 8'h00;
  localparam logic [PC_W-1:0] PC_RST = 15'h0000;
  typedef enum logic [2:0] {RRX_NONE, RRX_IEXIT, RRX_SEXIT, RRX_LEXIT,
                            RRX_ROTL, RRX_ROTR} rrx_op_type;
endpackage

// File: include/rrx_dec_if.sv
// interface: decoded instruction between decoder and execution logic
interface rrx_dec_if;
  rrx_pkg::rrx_op_type      op;
  logic [7:0]               lit;
  logic [rrx_pkg::ADDR_W-1:0] addr;
  logic                     dest;
  modport dec (output op, output lit, output addr, output dest);
  modport exe (input op, input lit, input addr, input dest);
endinterface

// File: hw/rrx_decode.sv
// decoder: classifies an instruction word into one of the five operations, or RRX_NONE for any other word
module rrx_decode (
  input  wire logic [rrx_pkg::WORD_W-1:0] instr,
  rrx_dec_if.dec                          dec
);
  logic [5:0] opc;
  assign opc      = instr[rrx_pkg::WORD_W-1:rrx_pkg::OPC_LSB];
  assign dec.lit  = instr[7:0];
  assign dec.addr = instr[rrx_pkg::ADDR_W-1:0];
  assign dec.dest = instr[rrx_pkg::DEST_BIT];
  always_comb
  begin
    if (instr == rrx_pkg::OP_RETFI)
      dec.op = rrx_pkg::RRX_IEXIT;
    else if (instr == rrx_pkg::OP_RETURN)
      dec.op = rrx_pkg::RRX_SEXIT;
    else if (opc == rrx_pkg::OP_RETLIT)
      dec.op = rrx_pkg::RRX_LEXIT;
    else if (opc == rrx_pkg::OP_ROTL)
      dec.op = rrx_pkg::RRX_ROTL;
    else if (opc == rrx_pkg::OP_ROTR)
      dec.op = rrx_pkg::RRX_ROTR;
    else
      dec.op = rrx_pkg::RRX_NONE;
  end
endmodule

// File: hw/rrx_exec.sv
// execution unit for return and rotate-through-carry instructions
module rrx_exec (
  input  wire logic                      CLK,
  input  wire logic                      RSTN,
  input  wire logic                      CE,
  input  wire logic                      INSTR_VALID,
  input  wire logic [13:0]               INSTR,
  input  wire logic [14:0]               STACK_TOP,
  input  wire logic [7:0]                FILE_RDATA,
  input  wire logic                      CARRY_IN,
  output logic                           READY,
  output logic                           STACK_POP,
  output logic [6:0]                     FILE_ADDR,
  output logic                           FILE_WE,
  output logic [7:0]                     FILE_WDATA,
  output logic                           CARRY_WE,
  output logic                           CARRY_OUT,
  output logic                           PC_LOAD,
  output logic [14:0]                    PC_OUT,
  output logic                           GLOBAL_IRQ_ENABLE_SET,
  output logic [7:0]                     W_OUT
);
  typedef enum {S_IDLE, S_SECOND} rrx_state_type;

  rrx_dec_if dif ();
  rrx_decode u_dec (
    .instr (INSTR),
    .dec   (dif)
  );

  rrx_state_type state_q;
  rrx_state_type state_d;
  logic [7:0]    w_q;
  logic [14:0]   pc_q;
  logic          pop_q;
  logic          pcld_q;
  logic          irq_set_q;
  logic          fwe_q;
  logic          cwe_q;
  logic          cout_q;
  logic [7:0]    fwd_q;
  logic [7:0]    rot_res;
  logic          rot_c;
  logic          is_ret;
  logic          is_rot;
  logic          take;

  assign take   = CE && INSTR_VALID && (state_q == S_IDLE);
  assign is_ret = (dif.op == rrx_pkg::RRX_IEXIT) || (dif.op == rrx_pkg::RRX_SEXIT)
               || (dif.op == rrx_pkg::RRX_LEXIT);
  assign is_rot = (dif.op == rrx_pkg::RRX_ROTL) || (dif.op == rrx_pkg::RRX_ROTR);
  // returns stall the fetch for their second cycle
  assign READY  = (state_q == S_IDLE);

  always_comb
  begin
    if (dif.op == rrx_pkg::RRX_ROTL)
    begin
      rot_res = {FILE_RDATA[6:0], CARRY_IN};
      rot_c   = FILE_RDATA[7];
    end
    else
    begin
      rot_res = {CARRY_IN, FILE_RDATA[7:1]};
      rot_c   = FILE_RDATA[0];
    end
  end

  always_comb
  begin
    case (state_q)
      S_IDLE:   state_d = (take && is_ret) ? S_SECOND : S_IDLE;
      S_SECOND: state_d = S_IDLE;
      default:  state_d = S_IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      state_q <= S_IDLE;
    else if (CE)
      state_q <= state_d;
  end

  // stack pop and program counter load pulse in the second (stall) cycle of any return
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      pop_q  <= 1'b0;
      pcld_q <= 1'b0;
      irq_set_q <= 1'h0;
      pc_q   <= rrx_pkg::PC_RST;
    end
    else if (CE)
    begin
      pop_q  <= take && is_ret;
      pcld_q <= take && is_ret;
      irq_set_q <= take && (dif.op == rrx_pkg::RRX_IEXIT);
      if (take && is_ret)
        pc_q <= STACK_TOP;
    end
  end

  // working register: literal exit or rotate with destination 0
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      w_q <= rrx_pkg::W_RST;
    else if (CE && take)
    begin
      if (dif.op == rrx_pkg::RRX_LEXIT)
        w_q <= dif.lit;
      else if (is_rot && !dif.dest)
        w_q <= rot_res;
    end
  end

  // file write-back and carry: rotates only, single cycle; returns touch no flag
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      fwe_q  <= 1'b0;
      cwe_q  <= 1'b0;
      cout_q <= 1'b0;
      fwd_q  <= 8'h00;
    end
    else if (CE)
    begin
      fwe_q <= take && is_rot && dif.dest;
      cwe_q <= take && is_rot;
      if (take && is_rot)
      begin
        cout_q <= rot_c;
        fwd_q  <= rot_res;
      end
    end
  end

  // the read address follows INSTR; a write-back lands one cycle later, so the
  // register file must keep the address of the rotate that it is writing
  assign FILE_ADDR  = dif.addr;
  assign FILE_WE    = fwe_q;
  assign FILE_WDATA = fwd_q;
  assign CARRY_WE   = cwe_q;
  assign CARRY_OUT  = cout_q;
  assign STACK_POP  = pop_q;
  assign PC_LOAD    = pcld_q;
  assign PC_OUT     = pc_q;
  assign GLOBAL_IRQ_ENABLE_SET = irq_set_q;
  assign W_OUT      = w_q;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  // antecedents sample the take; results are looked at one edge later
  sequence ret_taken;
    CE && take && is_ret;
  endsequence
  sequence rot_taken;
    CE && take && is_rot;
  endsequence
  sequence rotl_taken;
    CE && take && dif.op == rrx_pkg::RRX_ROTL;
  endsequence
  sequence rotr_taken;
    CE && take && dif.op == rrx_pkg::RRX_ROTR;
  endsequence
  sequence iexit_taken;
    CE && take && dif.op == rrx_pkg::RRX_IEXIT;
  endsequence
  sequence lexit_taken;
    CE && take && dif.op == rrx_pkg::RRX_LEXIT;
  endsequence
  sequence stall_offer;
    CE && INSTR_VALID && !READY;
  endsequence
  sequence two_cycle_busy;
    !READY ##1 READY;
  endsequence

  ret_pop_a: assert property (ret_taken |=> STACK_POP && PC_LOAD)
    else $error("return did not pop stack");
  ret_pc_a: assert property (ret_taken |=> PC_OUT == $past(STACK_TOP))
    else $error("pc not loaded from stack top");
  irq_set_a: assert property (iexit_taken |=> GLOBAL_IRQ_ENABLE_SET)
    else $error("interrupt exit did not set enable");
  irq_only_a: assert property (CE && take && dif.op != rrx_pkg::RRX_IEXIT
    |=> !GLOBAL_IRQ_ENABLE_SET)
    else $error("enable set by another instruction");
  // a held-off clock in the stall cycle stretches the return, so only count enabled cycles
  ret_cycles_a: assert property (ret_taken ##1 CE |-> two_cycle_busy)
    else $error("return not two cycles");
  ret_flags_a: assert property (ret_taken |=> !CARRY_WE && !FILE_WE)
    else $error("return touched flags");
  lit_w_a: assert property (lexit_taken |=> W_OUT == $past(INSTR[7:0]))
    else $error("literal not loaded in w");
  stall_drop_a: assert property (stall_offer |=> !CARRY_WE && !STACK_POP)
    else $error("instruction taken in stall cycle");

  rotl_val_a: assert property (rotl_taken |=> CARRY_OUT == $past(FILE_RDATA[7]))
    else $error("left rotate carry wrong");
  rotl_res_a: assert property (rotl_taken
    |=> FILE_WDATA == {$past(FILE_RDATA[6:0]), $past(CARRY_IN)})
    else $error("left rotate data wrong");
  rotr_val_a: assert property (rotr_taken |=> CARRY_OUT == $past(FILE_RDATA[0])
    && FILE_WDATA[7] == $past(CARRY_IN))
    else $error("right rotate result wrong");
  rotr_res_a: assert property (rotr_taken
    |=> FILE_WDATA == {$past(CARRY_IN), $past(FILE_RDATA[7:1])})
    else $error("right rotate data wrong");
  rot_dest_a: assert property (rot_taken |=> FILE_WE == $past(dif.dest))
    else $error("rotate destination wrong");
  w_keep_a: assert property (rot_taken ##0 dif.dest |=> W_OUT == $past(W_OUT))
    else $error("file destination changed w");
  w_rot_a: assert property (rot_taken ##0 !dif.dest |=> W_OUT == FILE_WDATA)
    else $error("w destination not written");
  rot_lsb_a: assert property (rotl_taken |=> FILE_WDATA[0] == $past(CARRY_IN))
    else $error("carry not in bit 0");
  rot_single_a: assert property (rot_taken |=> READY)
    else $error("rotate stalled");
  rot_stack_a: assert property (rot_taken |=> !STACK_POP && !PC_LOAD)
    else $error("rotate touched stack");
endmodule

// File: tb/test_return_rotate_exec.sv
// self-checking bench for the return and rotate execution unit
module test_return_rotate_exec;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rstn, ce, valid, cin, ready, pop, fwe, cwe, cout, pcl, irqs;
  logic [13:0] instr;
  logic [14:0] top, pc;
  logic [7:0]  rd, wd, w, exp_w;
  logic [6:0]  fa;
  logic [14:0] exp_pc;
  int          errors, cmp_count;

  rrx_exec u_dut (.CLK(clk), .RSTN(rstn), .CE(ce), .INSTR_VALID(valid), .INSTR(instr),
    .STACK_TOP(top), .FILE_RDATA(rd), .CARRY_IN(cin), .READY(ready), .STACK_POP(pop),
    .FILE_ADDR(fa), .FILE_WE(fwe), .FILE_WDATA(wd), .CARRY_WE(cwe), .CARRY_OUT(cout),
    .PC_LOAD(pcl), .PC_OUT(pc), .GLOBAL_IRQ_ENABLE_SET(irqs), .W_OUT(w));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // {new carry, result}
  function automatic logic [8:0] rot(input logic left, input logic [7:0] v, input logic c);
    rot = left ? {v, c} : {v[0], c, v[7:1]};
  endfunction

  // kind 0 subroutine, 1 interrupt, 2 literal; caller sits at a falling edge
  task automatic do_ret(input int kind, input logic [7:0] k, input logic [14:0] t);
    valid = 1'b1;
    top = t;
    instr = kind == 0 ? rrx_pkg::OP_RETURN : kind == 1 ? rrx_pkg::OP_RETFI
          : {rrx_pkg::OP_RETLIT, k};
    @(negedge clk);
    // offered in the stall cycle, so it must be ignored
    instr = {rrx_pkg::OP_ROTL, 1'b1, 7'h05};
    top = ~t;
    check(pc, t);
    check({pop, pcl}, 2'h3);
    check(irqs, kind == 1);
    if (kind == 2)
      exp_w = k;
    check(w, exp_w);
    check({ready, cwe}, 2'h0);
    @(negedge clk);
    check({ready, pop, pcl, irqs, cwe, fwe, pc}, {6'h20, t});
    exp_pc = t;
  endtask

  task automatic do_rot(input logic l, input logic d, input logic [6:0] a,
                        input logic [7:0] v, input logic c);
    logic [8:0] r;
    r = rot(l, v, c);
    valid = 1'b1;
    instr = {l ? rrx_pkg::OP_ROTL : rrx_pkg::OP_ROTR, d, a};
    rd = v;
    cin = c;
    #1 check(fa, a);
    @(negedge clk);
    check({cwe, cout}, {1'b1, r[8]});
    check({fwe, pop, pcl, irqs}, {d, 3'h0});
    if (d)
      check(wd, r[7:0]);
    else
      exp_w = r[7:0];
    check(w, exp_w);
    check(pc, exp_pc);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial
  begin
    #(8 * 5000);
    errors++;
    summarize();
  end

  initial
  begin
    {rstn, ce, valid, cin, instr, top, rd} = '0;
    errors = 0;
    cmp_count = 0;
    void'($urandom(65418));
    repeat (6) @(posedge clk);
    @(negedge clk);
    check({ready, pop, pcl, pc, w}, {3'h4, 15'h0, 8'h0});
    exp_w = rrx_pkg::W_RST;
    exp_pc = rrx_pkg::PC_RST;
    rstn = 1'b1;
    ce = 1'b1;
    do_rot(1'b1, 1'b0, 7'h7f, 8'he6, 1'b0);
    do_rot(1'b0, 1'b1, 7'h00, 8'h01, 1'b1);
    do_ret(2, 8'hff, 15'h7fff);
    do_ret(1, 8'h00, 15'h0000);
    do_ret(0, 8'h00, 15'h2aaa);
    repeat (60)
    begin
      case ($urandom_range(0, 4))
        0, 1, 2: do_ret($urandom_range(0, 2), 8'($urandom), 15'($urandom));
        default: do_rot(1'($urandom), 1'($urandom), 7'($urandom), 8'($urandom), 1'($urandom));
      endcase
    end
    // an opcode outside the five does nothing
    instr = 14'h3fff;
    @(negedge clk);
    check({ready, cwe, fwe, pop, pcl, irqs, w}, {6'h20, exp_w});
    check(pc, exp_pc);
    // a disabled clock freezes the last pulses and holds off the pending rotate
    do_rot(1'b0, 1'b1, 7'h11, 8'h5a, 1'b0);
    ce = 1'b0;
    rd = 8'h00;
    @(negedge clk);
    check({cwe, fwe, pop, wd}, {3'h6, 8'h2d});
    valid = 1'b0;
    ce = 1'b1;
    @(negedge clk);
    check({cwe, fwe, pop}, 3'h0);
    summarize();
  end
endmodule
